// ---- rtl/sta_alarm.sv ----
// Purpose: Limit comparison, sticky flags, peak/floor capture and alarm gating
// Assumes: Readings and error events are synchronous to core_clk
// Notes:   Registers reached over APB; 8-bit registers sit in the low byte
`timescale 1ns/100ps
`include "sta_cfg.svh"

// Operation
// R1 - Channel 0 reading above upper limit sets chan0 high flag when pin 0 sensed.
// R2 - Channel 0 reading below lower limit sets chan0 low flag when pin 0 sensed.
// R3 - Channel 1 reading above upper limit sets chan1 high flag when pin 1 sensed.
// R4 - Channel 1 reading below lower limit sets chan1 low flag when pin 1 sensed.
// R5 - Temperature above upper limit sets temp high flag while sensor enabled.
// R6 - Temperature below lower limit sets temp low flag while sensor enabled.
// R7 - Each voltage channel keeps its highest reading, readable by software.
// R8 - Each voltage channel keeps its lowest reading, readable by software.
// R9 - Missing frame alarm reported only while enable bit 5 is one; resets one.
// R10 - Phy sync and control alarms reported only while bits 4 and 3 set.
// R11 - Header ECC, checksum and length alarms gated by bits 2, 1, 0.
// R12 - Temperature over and under alarms gated by bits 5 and 4; reset zero.
// R13 - Channel 1 and 0 over and under alarms gated by bits 3..0; reset zero.
// R14 - Pin select code: 00 none, 01 pin 0, 10 pin 1, 11 both.
// R15 - Sensor enable field 11 turns monitors on, 00 off; resets to 11.
// R16 - Alarm output high while any flag is set with its enable at one.
module sta_alarm
    import sta_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Measurements
    input  wire logic              sample_valid,
    input  wire logic [2:0]        chan0_reading,
    input  wire logic [2:0]        chan1_reading,
    input  wire logic [2:0]        temp_reading,
    // Camera receive error events, one-cycle pulses
    input  wire logic [5:0]        cam_err_evt,
    // Alarm and interrupt
    output logic                   sensor_alarm,
    output logic                   irq
);

    localparam int NMON = 3;
    localparam int SW   = 8 + `STA_CAM_W;

    // Limit register index and reset value per monitor: ch0, ch1, temperature
    localparam logic [7:0] LIM_IDX [NMON] = '{`STA_IDX_V0_LIMITS,
                                              `STA_IDX_V1_LIMITS,
                                              `STA_IDX_T_LIMITS};
    localparam logic [7:0] LIM_RST [NMON] = '{`STA_RST_V_LIMITS,
                                              `STA_RST_V_LIMITS,
                                              `STA_RST_T_LIMITS};

    // Refuse an address bus too narrow for the highest index
    initial begin
        if (ADDR_W < 10) begin
            $error("sta_alarm: ADDR_W must be at least 10");
        end
    end

    // Status and mask must fit in one bus word
    initial begin
        if (SW > 32) begin
            $error("sta_alarm: status wider than the data bus");
        end
    end

    // Event input is fixed at six camera error kinds
    initial begin
        if (`STA_CAM_W != 6) begin
            $error("sta_alarm: camera event width must be 6");
        end
    end

    sta_bus_state_t    state_r;
    logic [7:0]        sense_ctrl_r;
    logic [7:0]        lim_r [NMON];
    logic [7:0]        cam_en_r;
    logic [7:0]        mon_en_r;
    logic [SW-1:0]     status_r;
    logic [SW-1:0]     irq_mask_r;
    sta_code_t         peak_r  [2];
    sta_code_t         floor_r [2];
    logic              wr_fire;
    logic [7:0]        idx;
    logic              addr_ok;
    logic [31:0]       rd_nxt;
    logic              hit;
    logic [SW-1:0]     set_vec;
    logic [SW-1:0]     clr_vec;
    logic [SW-1:0]     en_vec;
    logic [NMON-1:0]   mon_on;
    sta_code_t         reading [NMON];
    logic              sense_on;

    assign idx     = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
    // Write lands on the edge where the master samples pready high
    assign wr_fire = (state_r == STA_RESP) && psel && penable && pwrite && addr_ok;

    // Bus slave sequencing: one wait cycle, then pready for one cycle
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_r <= STA_IDLE;
        end else begin
            unique case (state_r)
                STA_IDLE: begin
                    if (psel && penable) begin
                        state_r <= STA_RESP;
                    end
                end
                STA_RESP: begin
                    state_r <= STA_HOLD;
                end
                STA_HOLD: begin
                    state_r <= STA_IDLE;
                end
            endcase
        end
    end

    // Answer flops; pready only in RESP, so outputs come straight from flops
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (state_r == STA_IDLE && psel && penable) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= !hit;
        end else begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Read decode; unmapped addresses read zero with an error
    always_comb begin
        rd_nxt = 32'h0000_0000;
        hit    = addr_ok;
        if (addr_ok) begin
            unique case (idx)
                `STA_IDX_SENSE_CTRL: rd_nxt[7:0] = sense_ctrl_r;
                `STA_IDX_V0_LIMITS:  rd_nxt[7:0] = lim_r[0];
                `STA_IDX_V1_LIMITS:  rd_nxt[7:0] = lim_r[1];
                `STA_IDX_T_LIMITS:   rd_nxt[7:0] = lim_r[2];
                `STA_IDX_CAM_EN:     rd_nxt[7:0] = cam_en_r;
                `STA_IDX_MON_EN:     rd_nxt[7:0] = mon_en_r;
                `STA_IDX_STATUS:     rd_nxt[SW-1:0] = status_r;
                `STA_IDX_IRQ_MASK:   rd_nxt[SW-1:0] = irq_mask_r;
                `STA_IDX_V0_PEAK:    rd_nxt[2:0] = peak_r[0];   // R7
                `STA_IDX_V0_FLOOR:   rd_nxt[2:0] = floor_r[0];  // R8
                `STA_IDX_V1_PEAK:    rd_nxt[2:0] = peak_r[1];   // R7
                `STA_IDX_V1_FLOOR:   rd_nxt[2:0] = floor_r[1];  // R8
                default:             hit = 1'b0;
            endcase
        end
    end

    // Control register: sensor enable and pin select
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sense_ctrl_r <= `STA_RST_SENSE_CTRL;  // R15
        end else if (wr_fire && idx == `STA_IDX_SENSE_CTRL) begin
            sense_ctrl_r <= pwdata[7:0];
        end
    end

    // Limit registers, full byte kept so reserved bits read back.
    // Upper limit in bits 6:4, lower limit in bits 2:0; a new limit
    // only affects samples taken after the write edge.
    for (genvar m = 0; m < NMON; m++) begin : g_lim
        always_ff @(posedge core_clk) begin
            if (!resetn) begin
                lim_r[m] <= LIM_RST[m];
            end else if (wr_fire && idx == LIM_IDX[m]) begin
                lim_r[m] <= pwdata[7:0];
            end
        end
    end

    // Alarm enable registers
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cam_en_r <= `STA_RST_CAM_EN;  // R9 R10 R11
            mon_en_r <= `STA_RST_MON_EN;  // R12 R13
        end else if (wr_fire) begin
            if (idx == `STA_IDX_CAM_EN) begin
                cam_en_r <= pwdata[7:0];
            end
            if (idx == `STA_IDX_MON_EN) begin
                mon_en_r <= pwdata[7:0];
            end
        end
    end

    // Interrupt mask, same layout as status
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq_mask_r <= `STA_RST_IRQ_MASK;
        end else if (wr_fire && idx == `STA_IDX_IRQ_MASK) begin
            irq_mask_r <= pwdata[SW-1:0];
        end
    end

    // Monitor activity: only code 11 powers the monitors
    assign sense_on = (sense_ctrl_r[`STA_CTRL_EN_MSB:`STA_CTRL_EN_LSB] == `STA_SENSE_ON);  // R15
    assign mon_on[0] = sense_on && sense_ctrl_r[`STA_CTRL_PIN_LSB];      // R14
    assign mon_on[1] = sense_on && sense_ctrl_r[`STA_CTRL_PIN_LSB + 1];  // R14
    assign mon_on[2] = sense_on;                                          // R5 R6
    assign reading[0] = chan0_reading;
    assign reading[1] = chan1_reading;
    assign reading[2] = temp_reading;

    // Per-monitor comparison; low flag at even bit, high flag at odd bit.
    // Strict compares: a reading equal to a limit raises nothing.
    // Continuous assigns keep each status bit with a single driver.
    for (genvar m = 0; m < NMON; m++) begin : g_cmp
        assign set_vec[2*m]   = sample_valid && mon_on[m]
                                && (reading[m] < lim_r[m][`STA_LIM_LO_MSB:`STA_LIM_LO_LSB]);  // R2 R4 R6
        assign set_vec[2*m+1] = sample_valid && mon_on[m]
                                && (reading[m] > lim_r[m][`STA_LIM_HI_MSB:`STA_LIM_HI_LSB]);  // R1 R3 R5
    end
    assign set_vec[7:6]   = 2'h0;
    assign set_vec[SW-1:8] = cam_err_evt;

    // Enable vector lined up with status bits
    assign en_vec[5:0]    = mon_en_r[5:0];   // R12 R13
    assign en_vec[7:6]    = 2'h0;
    assign en_vec[SW-1:8] = cam_en_r[5:0];   // R9 R10 R11

    // Write-one-to-clear vector; zero unless software writes status
    assign clr_vec = (wr_fire && idx == `STA_IDX_STATUS) ? pwdata[SW-1:0] : '0;

    // Sticky status; a new event beats a write-one-to-clear in the same cycle,
    // so an event landing on the clear edge is never lost
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~clr_vec) | set_vec;
        end
    end

    // Peak and floor capture per voltage channel, only while sensed
    for (genvar c = 0; c < 2; c++) begin : g_ext
        always_ff @(posedge core_clk) begin
            if (!resetn) begin
                peak_r[c]  <= 3'h0;
                floor_r[c] <= 3'h7;
            end else if (sample_valid && mon_on[c]) begin
                if (reading[c] > peak_r[c]) begin
                    peak_r[c] <= reading[c];   // R7
                end
                if (reading[c] < floor_r[c]) begin
                    floor_r[c] <= reading[c];  // R8
                end
            end
        end
    end

    // Alarm level from a flop; one cycle behind status, so it lags a
    // sample by two edges. Enables gate reporting, never flag setting.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sensor_alarm <= 1'b0;
        end else begin
            sensor_alarm <= |(status_r & en_vec);  // R9 R10 R11 R12 R13 R16
        end
    end

    // Interrupt level from a flop; gated by the mask alone
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & irq_mask_r);
        end
    end

endmodule // sta_alarm

// ---- rtl/sta_cfg.svh ----
// Purpose: Constants for the sensor threshold alarm block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Included by bare name from the design files
`ifndef STA_CFG_SVH
`define STA_CFG_SVH

// Register indices (byte address = index * 4)
`define STA_IDX_SENSE_CTRL   8'h17
`define STA_IDX_V0_LIMITS    8'h19
`define STA_IDX_V1_LIMITS    8'h1A
`define STA_IDX_T_LIMITS     8'h1B
`define STA_IDX_CAM_EN       8'h1C
`define STA_IDX_MON_EN       8'h1D
`define STA_IDX_STATUS       8'h40
`define STA_IDX_IRQ_MASK     8'h41
`define STA_IDX_V0_PEAK      8'h42
`define STA_IDX_V0_FLOOR     8'h43
`define STA_IDX_V1_PEAK      8'h44
`define STA_IDX_V1_FLOOR     8'h45

// Reset values
`define STA_RST_SENSE_CTRL   8'h3C
`define STA_RST_V_LIMITS     8'h62
`define STA_RST_T_LIMITS     8'h62
`define STA_RST_CAM_EN       8'h3F
`define STA_RST_MON_EN       8'h00
`define STA_RST_IRQ_MASK     14'h0000

// Field positions
`define STA_LIM_HI_MSB       6
`define STA_LIM_HI_LSB       4
`define STA_LIM_LO_MSB       2
`define STA_LIM_LO_LSB       0
`define STA_CTRL_EN_MSB      3
`define STA_CTRL_EN_LSB      2
`define STA_CTRL_PIN_MSB     1
`define STA_CTRL_PIN_LSB     0
`define STA_STAT_CAM_LSB     8
`define STA_CAM_W            6

// Sensor enable code for on
`define STA_SENSE_ON         2'h3

`endif

// ---- rtl/sta_pkg.sv ----
// Purpose: Types for the sensor threshold alarm block
// Assumes: Constants live in sta_cfg.svh
// Notes:   One-hot state codes for the bus slave
package sta_pkg;

    // Bus slave states
    typedef enum logic [2:0] {
        STA_IDLE = 3'b001,
        STA_RESP = 3'b010,
        STA_HOLD = 3'b100
    } sta_bus_state_t;

    // Limit and reading code
    typedef logic [2:0] sta_code_t;

endpackage

// ---- tb/sta_alarm_properties.sv ----
// Purpose: Port-level checks for the sensor threshold alarm block
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Alarm and irq only move after a sample, an event or a bus write
`timescale 1ns/100ps
module sta_alarm_properties (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Events and outputs
    input wire logic        sample_valid,
    input wire logic [5:0]  cam_err_evt,
    input wire logic        sensor_alarm,
    input wire logic        irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Levels rise two edges after their cause
    AST_ALARM_CAUSE: assert property ($rose(sensor_alarm) |->
        $past(sample_valid, 2) || ($past(cam_err_evt, 2) != 6'h0) ||
        $past(pready) || $past(pready, 2)) else $error("alarm rose without cause");
    AST_IRQ_CAUSE: assert property ($rose(irq) |->
        $past(sample_valid, 2) || ($past(cam_err_evt, 2) != 6'h0) ||
        $past(pready) || $past(pready, 2)) else $error("irq rose without cause");
    // Sticky flags: only a register write lowers a level
    AST_ALARM_STICKY: assert property ($fell(sensor_alarm) |->
        $past(pready) || $past(pready, 2)) else $error("alarm fell without write");
    AST_IRQ_STICKY: assert property ($fell(irq) |->
        $past(pready) || $past(pready, 2)) else $error("irq fell without write");
    // One wait state, one-cycle answer
    AST_READY_LATENCY: assert property (psel && penable && !$past(penable)
        |=> pready) else $error("pready not one cycle after access");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_READY_CAUSE: assert property (pready |-> $past(psel) && $past(penable))
        else $error("pready without access");
    AST_DATA_QUIET: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data outside answer");
    // Main scenarios
    cover property ($rose(sensor_alarm));
    cover property ($rose(irq));
    cover property (pready && pslverr);
endmodule // sta_alarm_properties

bind sta_alarm sta_alarm_properties u_props (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sample_valid(sample_valid), .cam_err_evt(cam_err_evt),
    .sensor_alarm(sensor_alarm), .irq(irq));

// ---- tb/sensor_threshold_alarm_logic_tb.sv ----
// Purpose: Register-level tests of the sensor threshold alarm block
// Assumes: Byte address is four times the register index
// Notes:   Readings are inverted while not valid to expose stale captures
`timescale 1ns/100ps
module sensor_threshold_alarm_logic_tb
    import sta_pkg::*;
;
    // Design signals
    logic        core_clk, resetn, psel, penable, pwrite, sample_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic        pready, pslverr, sensor_alarm, irq, err_q;
    logic [2:0]  chan0_reading, chan1_reading, temp_reading;
    logic [5:0]  cam_err_evt;
    int          n_errors = 0;
    int          check_count = 0;
    // Reset table
    logic [7:0]  ridx [12] = '{8'h17, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D,
                               8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45};
    logic [31:0] rexp [12] = '{32'h3C, 32'h62, 32'h62, 32'h62, 32'h3F, 32'h0,
                               32'h0, 32'h0, 32'h0, 32'h7, 32'h0, 32'h7};

    sta_alarm #(.ADDR_W(12)) uut (
        .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .sample_valid(sample_valid),
        .chan0_reading(chan0_reading), .chan1_reading(chan1_reading),
        .temp_reading(temp_reading), .cam_err_evt(cam_err_evt),
        .sensor_alarm(sensor_alarm), .irq(irq));

    // 100 MHz clock
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    // Compare and count
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask

    // One APB transfer, held until pready
    task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) n_errors++;
    endtask

    task rd(input logic [7:0] idx, input logic [31:0] e);
        xfer(1'b0, idx, 32'h0);
        chk(rd_q, e);
        chk(err_q, 1'b0);
    endtask

    // One valid sample, then garbage readings
    task smp(input logic [2:0] a, input logic [2:0] b, input logic [2:0] t);
        @(posedge core_clk);
        sample_valid <= 1'b1;
        chan0_reading <= a;
        chan1_reading <= b;
        temp_reading <= t;
        @(posedge core_clk);
        sample_valid <= 1'b0;
        chan0_reading <= ~a;
        chan1_reading <= ~b;
        temp_reading <= ~t;
        repeat (2) @(posedge core_clk);
    endtask

    task evt(input logic [5:0] b);
        @(posedge core_clk);
        cam_err_evt <= b;
        @(posedge core_clk);
        cam_err_evt <= 6'h0;
    endtask

    // Levels settle two edges after their cause
    task lvl(input logic a, input logic i);
        repeat (3) @(posedge core_clk);
        chk(sensor_alarm, a);
        chk(irq, i);
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog, well beyond the expected run
    initial begin
        #100000;
        n_errors++;
        tally_and_finish;
    end

    // Test sequence
    initial begin
        {resetn, psel, penable, pwrite, sample_valid} = 5'h0;
        {paddr, pwdata, chan0_reading, chan1_reading} = 50'h0;
        {temp_reading, cam_err_evt} = 9'h0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 12; i++) rd(ridx[i], rexp[i]);
        xfer(1'b0, 8'h30, 32'h0);
        chk(err_q, 1'b1);
        $display("reset test done");
        smp(3'h7, 3'h0, 3'h7);
        rd(8'h40, 32'h20);
        xfer(1'b1, 8'h40, 32'h3F);
        for (int c = 1; c < 4; c++) begin
            xfer(1'b1, 8'h17, 32'h3C | c);
            smp(3'h7, 3'h0, 3'h4);
            rd(8'h40, (c[0] ? 32'h2 : 32'h0) | (c[1] ? 32'h4 : 32'h0));
            xfer(1'b1, 8'h40, 32'h3F);
        end
        smp(3'h6, 3'h2, 3'h6);
        rd(8'h40, 32'h0);
        smp(3'h1, 3'h7, 3'h1);
        rd(8'h40, 32'h19);
        rd(8'h42, 32'h7);
        rd(8'h43, 32'h1);
        rd(8'h44, 32'h7);
        rd(8'h45, 32'h0);
        xfer(1'b1, 8'h42, 32'h0);
        rd(8'h42, 32'h7);
        xfer(1'b1, 8'h40, 32'h3F);
        xfer(1'b1, 8'h17, 32'h33);
        smp(3'h7, 3'h7, 3'h7);
        rd(8'h40, 32'h0);
        xfer(1'b1, 8'h17, 32'h3D);
        xfer(1'b1, 8'h19, 32'h31);
        smp(3'h4, 3'h7, 3'h4);
        rd(8'h40, 32'h2);
        xfer(1'b1, 8'h40, 32'h3F);
        $display("threshold test done");
        smp(3'h2, 3'h0, 3'h7);
        lvl(1'b0, 1'b0);
        xfer(1'b1, 8'h1D, 32'h20);
        lvl(1'b1, 1'b0);
        xfer(1'b1, 8'h41, 32'h20);
        lvl(1'b1, 1'b1);
        xfer(1'b1, 8'h1D, 32'h1F);
        lvl(1'b0, 1'b1);
        xfer(1'b1, 8'h40, 32'h20);
        lvl(1'b0, 1'b0);
        $display("alarm test done");
        for (int i = 0; i < 6; i++) begin
            xfer(1'b1, 8'h1C, 32'h3F ^ (32'h1 << i));
            evt(6'h1 << i);
            lvl(1'b0, 1'b0);
            rd(8'h40, 32'h100 << i);
            xfer(1'b1, 8'h1C, 32'h3F);
            lvl(1'b1, 1'b0);
            xfer(1'b1, 8'h40, 32'h100 << i);
        end
        $display("camera test done");
        tally_and_finish;
    end
endmodule // sensor_threshold_alarm_logic_tb
